// *** verilog/pwmotc_pkg.sv ***
// package for the pwm output and trigger conditioning stage.
// assumes one 250 mhz clock and an active-low asynchronous reset.
//
// Behaviour
// - main dead time is 14 unsigned bits; bits 15-14 read zero.
// - separate alternate 14-bit dead time register for the same unit.
// - divider passes one trigger out of every N+1 trigger events.
// - after enable, wait start-field pwm cycles before the first trigger.
// - a secondary generator never raises trigger interrupts.
// - owner bit one gives the pin to pwm, zero to general io.
// - polarity bit one makes that output active-low.
// - mode 00 complementary, 01 redundant, 10 push-pull; 11 reserved.
// - force enable makes the pin follow its force value bit.
// - active fault drives pins to the fault value bits.
// - active current limit drives pins to the limit value bits.
// - swap exchanges high and low generated signals between pins.
// - sync set applies forces at cycle boundary, clear on next clock.
// - with write lock set, pin control writes need the unlock first.
// - trigger control bits 11-6 ignore writes and read zero.
// - trigger compare is matched against the local time base.
// - dead time select: 11 compensation, 10 off, 01 negative, 00 positive.
// - fault mode 01 cycle-by-cycle, 00 latched, 11 ignores the fault.
package pwmotc_pkg;
	// ==========================================================
	// bus geometry and register map
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned DT_W = 14;
	localparam logic [ADDR_W-1:0] OFS_MAIN_DT = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_ALT_DT = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_TRG_CTL = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_PIN_CTL = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_TRG_CMP = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_MODE = 3'h5;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] DT_MASK = 16'h3fff;
	localparam logic [DATA_W-1:0] TRG_CTL_MASK = 16'hf03f;
	localparam logic [DATA_W-1:0] MODE_MASK = 16'h0037;
	// ==========================================================
	// field positions
	localparam int unsigned PC_HOWN = 15;
	localparam int unsigned PC_LOWN = 14;
	localparam int unsigned PC_HINV = 13;
	localparam int unsigned PC_LINV = 12;
	localparam int unsigned PC_MODE_LO = 10;
	localparam int unsigned PC_HFEN = 9;
	localparam int unsigned PC_LFEN = 8;
	localparam int unsigned PC_FVAL_LO = 6;
	localparam int unsigned PC_FLT_LO = 4;
	localparam int unsigned PC_LIM_LO = 2;
	localparam int unsigned PC_SWAP = 1;
	localparam int unsigned PC_SYNC = 0;
	localparam int unsigned TC_DIV_LO = 12;
	localparam int unsigned TC_DIV_W = 4;
	localparam int unsigned TC_STRT_LO = 0;
	localparam int unsigned TC_STRT_W = 6;
	localparam int unsigned MD_FLT_LO = 0;
	localparam int unsigned MD_LIM = 2;
	localparam int unsigned MD_DTS_LO = 4;
	// ==========================================================
	// mode encodings and states
	typedef enum logic [1:0] {
		PM_COMPL = 2'b00,
		PM_REDUN = 2'b01,
		PM_PUSH = 2'b10,
		PM_RSVD = 2'b11
	} pwmotc_pmode_t;
	typedef enum logic [1:0] {
		FM_LATCH = 2'b00,
		FM_CYCLE = 2'b01,
		FM_RSVD = 2'b10,
		FM_OFF = 2'b11
	} pwmotc_fmode_t;
	typedef enum logic [1:0] {
		DS_POS = 2'b00,
		DS_NEG = 2'b01,
		DS_OFF = 2'b10,
		DS_COMP = 2'b11
	} pwmotc_dts_t;
	typedef enum logic {
		FS_IDLE = 1'b0,
		FS_FORCE = 1'b1
	} pwmotc_fstate_t;
endpackage : pwmotc_pkg

// *** verilog/pwmotc_trigger.sv ***
// trigger start delay and output divider for one pwm generator.
// assumes event and cycle-start pulses are one clock long, same clock.
`timescale 1ns/1ps
module pwmotc_trigger #(
	parameter int unsigned DIV_W = 4,
	parameter int unsigned STRT_W = 6
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_module_enable,
	input wire logic i_cycle_start,
	input wire logic i_event,
	input wire logic [DIV_W-1:0] i_divider,
	input wire logic [STRT_W-1:0] i_start_delay,
	output logic o_trigger
);
	import pwmotc_pkg::*;
	logic en_d_reg, en_d_next;
	logic armed_reg, armed_next;
	logic [STRT_W-1:0] delay_reg, delay_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic trig_reg, trig_next;
	logic en_rise;
	assign en_rise = i_module_enable & ~en_d_reg;

	// ==========================================================
	// delay then divide; an event in the arming cycle is still held off
	always_comb begin
		en_d_next = i_module_enable;
		armed_next = armed_reg;
		delay_next = delay_reg;
		div_next = div_reg;
		trig_next = 1'b0;
		if (!i_module_enable) begin
			armed_next = 1'b0;
			div_next = '0;
		end else if (en_rise) begin
			delay_next = i_start_delay;
			armed_next = (i_start_delay == '0);
			div_next = '0;
		end else if (!armed_reg) begin
			if (i_cycle_start) begin
				delay_next = delay_reg - 1'b1;
				armed_next = (delay_reg <= 1);
			end
		end else if (i_event) begin
			if (div_reg == i_divider) begin
				trig_next = 1'b1;
				div_next = '0;
			end else begin
				div_next = div_reg + 1'b1;
			end
		end
	end

	// registers only
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			en_d_reg <= 1'b0;
			armed_reg <= 1'b0;
			delay_reg <= '0;
			div_reg <= '0;
			trig_reg <= 1'b0;
		end else begin
			en_d_reg <= en_d_next;
			armed_reg <= armed_next;
			delay_reg <= delay_next;
			div_reg <= div_next;
			trig_reg <= trig_next;
		end
	end
	assign o_trigger = trig_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	a_div_count_match: assert property (o_trigger |->
		$past(div_reg) == $past(i_divider))
		else $error("trigger passed before divider count reached");
	a_start_holds_off: assert property (
		en_rise && i_start_delay != '0 |=> !armed_reg ##1 !o_trigger)
		else $error("trigger armed before start delay elapsed");
endmodule : pwmotc_trigger

// *** verilog/pwmotc_top.sv ***
// pwm output conditioning, dead-time values and adc trigger unit.
// assumes waveform, fault, limit and time base inputs are on i_clock;
// the fault and limit inputs are already source-selected and blanked.
`timescale 1ns/1ps
module pwmotc_top #(
	parameter bit IS_PRIMARY = 1'b1
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [pwmotc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [pwmotc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [pwmotc_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_config_write_lock,
	input wire logic i_unlock_pulse,
	input wire logic i_module_enable,
	input wire logic i_cycle_start,
	input wire logic i_local_time_base,
	input wire logic [pwmotc_pkg::DATA_W-1:0] i_time_base,
	input wire logic i_gen_high,
	input wire logic i_gen_low,
	input wire logic i_fault_active,
	input wire logic i_limit_active,
	output logic o_high_side_output,
	output logic o_low_side_output,
	output logic o_high_pin_owner,
	output logic o_low_pin_owner,
	output logic [pwmotc_pkg::DT_W-1:0] o_rise_dead_time,
	output logic [pwmotc_pkg::DT_W-1:0] o_fall_dead_time,
	output logic o_dead_time_negative,
	output logic o_dead_time_comp,
	output logic o_adc_trigger,
	output logic o_trigger_irq
);
	import pwmotc_pkg::*;
	// ==========================================================
	// register file state
	logic [DATA_W-1:0] main_dt_reg, main_dt_next;
	logic [DATA_W-1:0] alt_dt_reg, alt_dt_next;
	logic [DATA_W-1:0] trg_ctl_reg, trg_ctl_next;
	logic [DATA_W-1:0] pin_ctl_reg, pin_ctl_next;
	logic [DATA_W-1:0] trg_cmp_reg, trg_cmp_next;
	logic [DATA_W-1:0] mode_reg, mode_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic unlock_reg, unlock_next;
	logic pin_wr, pin_wr_ok, mode_wr;
	pwmotc_pmode_t pmode;
	pwmotc_fmode_t fmode;
	pwmotc_dts_t dts;

	assign pin_wr = i_wr && (i_addr == OFS_PIN_CTL);
	assign mode_wr = i_wr && (i_addr == OFS_MODE);
	// locked writes are dropped silently, the bus never stalls
	assign pin_wr_ok = !i_config_write_lock || unlock_reg;
	assign pmode = pwmotc_pmode_t'(pin_ctl_reg[PC_MODE_LO +: 2]);
	assign fmode = pwmotc_fmode_t'(mode_reg[MD_FLT_LO +: 2]);
	assign dts = pwmotc_dts_t'(mode_reg[MD_DTS_LO +: 2]);

	// dead time, trigger control and mode writes store masked values; reads answer one cycle later
	always_comb begin
		main_dt_next = main_dt_reg;
		alt_dt_next = alt_dt_reg;
		trg_ctl_next = trg_ctl_reg;
		pin_ctl_next = pin_ctl_reg;
		trg_cmp_next = trg_cmp_reg;
		mode_next = mode_reg;
		unlock_next = unlock_reg;
		rdata_next = REG_RESET;
		if (pin_wr && pin_wr_ok)
			unlock_next = 1'b0; // one unlock admits one write
		if (i_unlock_pulse)
			unlock_next = 1'b1;
		if (i_wr) begin
			case (i_addr)
				OFS_MAIN_DT: main_dt_next = i_wdata & DT_MASK;
				OFS_ALT_DT: alt_dt_next = i_wdata & DT_MASK;
				OFS_TRG_CTL: trg_ctl_next = i_wdata & TRG_CTL_MASK;
				OFS_PIN_CTL: begin
					if (pin_wr_ok)
						pin_ctl_next = i_wdata;
				end
				OFS_TRG_CMP: trg_cmp_next = i_wdata;
				OFS_MODE: mode_next = i_wdata & MODE_MASK;
				default: ;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				OFS_MAIN_DT: rdata_next = main_dt_reg;
				OFS_ALT_DT: rdata_next = alt_dt_reg;
				OFS_TRG_CTL: rdata_next = trg_ctl_reg;
				OFS_PIN_CTL: rdata_next = pin_ctl_reg;
				OFS_TRG_CMP: rdata_next = trg_cmp_reg;
				OFS_MODE: rdata_next = mode_reg;
				default: rdata_next = REG_RESET;
			endcase
		end
	end

	// everything clears at reset: gpio owns pins, no forces
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			main_dt_reg <= REG_RESET;
			alt_dt_reg <= REG_RESET;
			trg_ctl_reg <= REG_RESET;
			pin_ctl_reg <= REG_RESET;
			trg_cmp_reg <= REG_RESET;
			mode_reg <= REG_RESET;
			rdata_reg <= REG_RESET;
			unlock_reg <= 1'b0;
		end else begin
			main_dt_reg <= main_dt_next;
			alt_dt_reg <= alt_dt_next;
			trg_ctl_reg <= trg_ctl_next;
			pin_ctl_reg <= pin_ctl_next;
			trg_cmp_reg <= trg_cmp_next;
			mode_reg <= mode_next;
			rdata_reg <= rdata_next;
			unlock_reg <= unlock_next;
		end
	end
	assign o_rdata = rdata_reg;

	// ==========================================================
	// fault and current-limit forcing state
	pwmotc_fstate_t fstate_reg, fstate_next;
	logic lim_hold_reg, lim_hold_next;
	logic fault_forced, limit_forced, fault_used;

	assign fault_used = (fmode == FM_LATCH) || (fmode == FM_CYCLE);
	assign fault_forced = fault_used &&
		(i_fault_active || fstate_reg == FS_FORCE);
	assign limit_forced = mode_reg[MD_LIM] &&
		(i_limit_active || lim_hold_reg);

	// latched faults clear only by a mode write with the input quiet;
	// a still-active fault wins over that clear
	always_comb begin
		fstate_next = fstate_reg;
		lim_hold_next = lim_hold_reg;
		case (fstate_reg)
			FS_IDLE: begin
				if (fault_used && i_fault_active)
					fstate_next = FS_FORCE;
			end
			FS_FORCE: begin
				if (!fault_used)
					fstate_next = FS_IDLE;
				else if (i_fault_active)
					fstate_next = FS_FORCE;
				else if (fmode == FM_CYCLE && i_cycle_start)
					fstate_next = FS_IDLE;
				else if (fmode == FM_LATCH && mode_wr)
					fstate_next = FS_IDLE;
			end
			default: fstate_next = FS_IDLE;
		endcase
		if (!mode_reg[MD_LIM])
			lim_hold_next = 1'b0;
		else if (i_limit_active)
			lim_hold_next = 1'b1;
		else if (i_cycle_start)
			lim_hold_next = 1'b0;
	end

	// registers only
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			fstate_reg <= FS_IDLE;
			lim_hold_reg <= 1'b0;
		end else begin
			fstate_reg <= fstate_next;
			lim_hold_reg <= lim_hold_next;
		end
	end

	// ==========================================================
	// force shadow and push-pull phase
	logic [1:0] force_en_reg, force_en_next;
	logic [1:0] force_val_reg, force_val_next;
	logic pp_phase_reg, pp_phase_next;

	// synced forces wait for the boundary to avoid runt pulses
	always_comb begin
		force_en_next = {pin_ctl_reg[PC_HFEN], pin_ctl_reg[PC_LFEN]};
		force_val_next = pin_ctl_reg[PC_FVAL_LO +: 2];
		if (pin_ctl_reg[PC_SYNC] && !i_cycle_start) begin
			force_en_next = force_en_reg;
			force_val_next = force_val_reg;
		end
		pp_phase_next = pp_phase_reg;
		if (!i_module_enable)
			pp_phase_next = 1'b0;
		else if (i_cycle_start)
			pp_phase_next = ~pp_phase_reg;
	end

	// registers only
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			force_en_reg <= 2'h0;
			force_val_reg <= 2'h0;
			pp_phase_reg <= 1'b0;
		end else begin
			force_en_reg <= force_en_next;
			force_val_reg <= force_val_next;
			pp_phase_reg <= pp_phase_next;
		end
	end

	// ==========================================================
	// output pin pair conditioning
	logic out_h_reg, out_h_next, out_l_reg, out_l_next;
	logic mh, ml, sh, sl, fh, fl;

	// mode, swap, force, limit, fault, polarity, ownership in that order
	always_comb begin
		case (pmode)
			PM_COMPL: begin
				mh = i_gen_high;
				ml = i_gen_low; // generator supplies the complement
			end
			PM_REDUN: begin
				mh = i_gen_high;
				ml = i_gen_high;
			end
			PM_PUSH: begin
				mh = i_gen_high & ~pp_phase_reg;
				ml = i_gen_high & pp_phase_reg;
			end
			default: begin
				mh = 1'b0; // reserved code parks both low
				ml = 1'b0;
			end
		endcase
		sh = pin_ctl_reg[PC_SWAP] ? ml : mh;
		sl = pin_ctl_reg[PC_SWAP] ? mh : ml;
		fh = force_en_reg[1] ? force_val_reg[1] : sh;
		fl = force_en_reg[0] ? force_val_reg[0] : sl;
		if (limit_forced) begin
			fh = pin_ctl_reg[PC_LIM_LO + 1];
			fl = pin_ctl_reg[PC_LIM_LO];
		end
		if (fault_forced) begin
			fh = pin_ctl_reg[PC_FLT_LO + 1];
			fl = pin_ctl_reg[PC_FLT_LO];
		end
		out_h_next = pin_ctl_reg[PC_HOWN] &
			(fh ^ pin_ctl_reg[PC_HINV]);
		out_l_next = pin_ctl_reg[PC_LOWN] &
			(fl ^ pin_ctl_reg[PC_LINV]);
	end

	// registers only
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			out_h_reg <= 1'b0;
			out_l_reg <= 1'b0;
		end else begin
			out_h_reg <= out_h_next;
			out_l_reg <= out_l_next;
		end
	end
	assign o_high_side_output = out_h_reg;
	assign o_low_side_output = out_l_reg;
	assign o_high_pin_owner = pin_ctl_reg[PC_HOWN];
	assign o_low_pin_owner = pin_ctl_reg[PC_LOWN];

	// ==========================================================
	// dead-time values for the neighbouring dead-time unit
	always_comb begin
		o_rise_dead_time = main_dt_reg[DT_W-1:0];
		o_fall_dead_time = alt_dt_reg[DT_W-1:0];
		if (dts == DS_OFF) begin
			o_rise_dead_time = '0;
			o_fall_dead_time = '0;
		end
		// negative dead time only means anything in complementary mode
		o_dead_time_negative = (dts == DS_NEG) && (pmode == PM_COMPL);
		o_dead_time_comp = (dts == DS_COMP);
	end

	// ==========================================================
	// adc trigger: compare match edge, delay and divide
	logic match_reg, match_next, trig_event, trig_out;
	assign match_next = (i_time_base == trg_cmp_reg);
	// one event per match, even if the time base idles on the value
	assign trig_event = i_local_time_base && match_next &&
		!match_reg;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			match_reg <= 1'b0;
		else
			match_reg <= match_next;
	end

	pwmotc_trigger #(
		.DIV_W(TC_DIV_W),
		.STRT_W(TC_STRT_W)
	) u_trigger (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_module_enable(i_module_enable),
		.i_cycle_start(i_cycle_start),
		.i_event(trig_event),
		.i_divider(trg_ctl_reg[TC_DIV_LO +: TC_DIV_W]),
		.i_start_delay(trg_ctl_reg[TC_STRT_LO +: TC_STRT_W]),
		.o_trigger(trig_out)
	);
	assign o_adc_trigger = trig_out;
	assign o_trigger_irq = IS_PRIMARY & trig_out;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	sequence s_alt_write;
		i_wr && i_addr == OFS_ALT_DT;
	endsequence
	sequence s_alt_read;
		i_rd && i_addr == OFS_ALT_DT && !i_wr;
	endsequence
	a_dt_upper_zero: assert property (i_rd && i_addr == OFS_MAIN_DT
		|=> o_rdata[15:14] == 2'h0)
		else $error("main dead time upper bits not zero");
	a_alt_dt_kept: assert property (s_alt_write ##1 s_alt_read
		|=> o_rdata == ($past(i_wdata, 2) & DT_MASK))
		else $error("alternate dead time not stored");
	a_secondary_no_irq: assert property (!IS_PRIMARY |-> !o_trigger_irq)
		else $error("secondary generator raised irq");
	a_owner_gpio: assert property (!pin_ctl_reg[PC_HOWN]
		|=> !o_high_side_output)
		else $error("unowned high pin driven");
	a_fault_data: assert property (fault_forced && pin_ctl_reg[PC_LOWN]
		|=> o_low_side_output == ($past(pin_ctl_reg[PC_FLT_LO]) ^
		$past(pin_ctl_reg[PC_LINV])))
		else $error("fault value not on low pin");
	a_limit_data: assert property (limit_forced && !fault_forced &&
		pin_ctl_reg[PC_HOWN] |=> o_high_side_output ==
		($past(pin_ctl_reg[PC_LIM_LO + 1]) ^
		$past(pin_ctl_reg[PC_HINV])))
		else $error("limit value not on high pin");
	a_lock_blocks: assert property (i_config_write_lock && !unlock_reg &&
		pin_wr |=> $stable(pin_ctl_reg))
		else $error("locked pin control accepted a write");
	a_trg_ctl_zero: assert property (i_rd && i_addr == OFS_TRG_CTL
		|=> o_rdata[11:6] == 6'h00)
		else $error("trigger control reserved bits not zero");
	a_sync_hold: assert property (pin_ctl_reg[PC_SYNC] && !i_cycle_start
		|=> $stable(force_en_reg) && $stable(force_val_reg))
		else $error("synced force changed off boundary");
endmodule : pwmotc_top

// *** sim/pwmotc_stage.sv ***
// model of the gate driver stage hanging on the pwm pin pair.
// assumes the pin levels and owner flags are sampled on the pwm clock.
`timescale 1ns/1ps
module pwmotc_stage (
	input wire logic i_drive_high,
	input wire logic i_drive_low,
	input wire logic i_own_high,
	input wire logic i_own_low,
	output logic o_gate_high,
	output logic o_gate_low
);
	// ==========================================================
	// pin levels seen by the driver
	// an unowned pin is left to general io, which this bench never drives,
	// so the driver input pull-down takes it low
	assign o_gate_high = i_own_high ? i_drive_high : 1'b0;
	assign o_gate_low = i_own_low ? i_drive_low : 1'b0;
endmodule : pwmotc_stage

// *** sim/pwmotc_top_tb.sv ***
// self-checking bench for the pwm output and trigger stage.
// assumes the design package is compiled first; one 250 mhz clock.
`timescale 1ns/1ps
module pwmotc_top_tb;
	import pwmotc_pkg::*;
	logic i_clock, i_resetn, i_wr, i_rd, i_config_write_lock;
	logic i_unlock_pulse, i_module_enable, i_cycle_start;
	logic i_local_time_base, i_gen_high, i_gen_low;
	logic i_fault_active, i_limit_active, rd_seen, p_h, p_l, irq2, trg2;
	logic [2:0] i_addr;
	logic [15:0] i_wdata, i_time_base, o_rdata, r;
	logic o_high_side_output, o_low_side_output, o_high_pin_owner;
	logic o_low_pin_owner, o_dead_time_negative, o_dead_time_comp;
	logic o_adc_trigger, o_trigger_irq;
	logic [13:0] o_rise_dead_time, o_fall_dead_time;
	logic [15:0] rq[$];
	int n_fail, n_checks, n_trg, n_irq, n_irq2, n_trg2, cyc;
	// ==========================================================
	// design, secondary copy and driver stage
	pwmotc_top #(.IS_PRIMARY(1'b1)) i_dut (.i_clock, .i_resetn, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_config_write_lock,
		.i_unlock_pulse, .i_module_enable, .i_cycle_start,
		.i_local_time_base, .i_time_base, .i_gen_high, .i_gen_low,
		.i_fault_active, .i_limit_active, .o_high_side_output,
		.o_low_side_output, .o_high_pin_owner, .o_low_pin_owner,
		.o_rise_dead_time, .o_fall_dead_time, .o_dead_time_negative,
		.o_dead_time_comp, .o_adc_trigger, .o_trigger_irq);
	pwmotc_top #(.IS_PRIMARY(1'b0)) i_dut_sec (.i_clock, .i_resetn,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(),
		.i_config_write_lock, .i_unlock_pulse, .i_module_enable,
		.i_cycle_start, .i_local_time_base, .i_time_base, .i_gen_high,
		.i_gen_low, .i_fault_active, .i_limit_active,
		.o_high_side_output(), .o_low_side_output(), .o_high_pin_owner(),
		.o_low_pin_owner(), .o_rise_dead_time(), .o_fall_dead_time(),
		.o_dead_time_negative(), .o_dead_time_comp(), .o_adc_trigger(trg2),
		.o_trigger_irq(irq2));
	pwmotc_stage i_stage (.i_drive_high(o_high_side_output),
		.i_drive_low(o_low_side_output), .i_own_high(o_high_pin_owner),
		.i_own_low(o_low_pin_owner), .o_gate_high(p_h), .o_gate_low(p_l));
	// low waveform is the complement, as the generator would supply it
	assign i_gen_low = ~i_gen_high;
	// ==========================================================
	// clock
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	// a gap cycle after each strobe keeps every signal to one write a step
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		rq.push_back(e);
		@(posedge i_clock);
		i_rd <= 1'b0;
	endtask : rd
	// write then read back with no gap; the read strobe rises as the write strobe drops
	task automatic wrd(input logic [2:0] a, input logic [15:0] d,
		input logic [15:0] e);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		rq.push_back(e);
		@(posedge i_clock);
		i_rd <= 1'b0;
	endtask : wrd
	task automatic cs(input int n);
		repeat (n) begin
			@(posedge i_clock);
			i_cycle_start <= 1'b1;
			@(posedge i_clock);
			i_cycle_start <= 1'b0;
		end
	endtask : cs
	task automatic ev(input int n);
		repeat (n) begin
			@(posedge i_clock);
			i_time_base <= 16'h0010;
			@(posedge i_clock);
			i_time_base <= 16'h0000;
		end
	endtask : ev
	// covers the copy lag of forces plus the output register stage
	task automatic pins(input logic h, input logic l);
		repeat (3) @(posedge i_clock);
		#1;
		chk({14'h0000, p_h, p_l}, {14'h0000, h, l});
	endtask : pins
	task automatic trg(input logic [3:0] dv, input logic [5:0] st,
		input logic lt, input int pre, input int post, input int e);
		wr(OFS_TRG_CTL, {dv, 6'h00, st});
		@(posedge i_clock);
		i_local_time_base <= lt;
		i_module_enable <= 1'b1;
		#1;
		n_trg = 0;
		n_irq = 0;
		cs((st > 0) ? st - 1 : 0);
		ev(pre);
		cs((st > 0) ? 1 : 0);
		ev(post);
		repeat (4) @(posedge i_clock);
		chk(16'(n_trg), 16'(e));
		chk(16'(n_irq), 16'(e));
		@(posedge i_clock);
		i_module_enable <= 1'b0;
	endtask : trg
	// ==========================================================
	// read watcher: the word stands in the cycle after the strobe only
	always @(posedge i_clock) begin
		if (rd_seen === 1'b1) begin
			chk(o_rdata, rq.pop_front());
		end
		rd_seen <= i_rd;
	end
	// trigger pulse counters and hang guard
	always @(posedge i_clock) begin
		if (o_adc_trigger === 1'b1) n_trg++;
		if (o_trigger_irq === 1'b1) n_irq++;
		if (irq2 !== 1'b0) n_irq2++;
		if (trg2 === 1'b1) n_trg2++;
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			test_done();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [15:0] pc;
		logic [15:0] s;
		logic h;
		logic l;
		{i_wr, i_rd, i_config_write_lock, i_unlock_pulse} = 4'h0;
		{i_module_enable, i_cycle_start, i_local_time_base} = 3'h0;
		{i_gen_high, i_fault_active, i_limit_active, rd_seen} = 4'h0;
		i_addr = 3'h0;
		i_wdata = 16'h0000;
		i_time_base = 16'h0000;
		r = 16'h2f13;
		i_resetn = 1'b0;
		repeat (6) @(posedge i_clock);
		i_resetn <= 1'b1;
		for (int a = 0; a < 8; a++) rd(3'(a), REG_RESET);
		pins(1'b0, 1'b0);
		$display("test reset done");
		for (int a = 0; a < 8; a++) if (a != 3) wr(3'(a), 16'hffff);
		rd(OFS_MAIN_DT, 16'h3fff);
		rd(OFS_ALT_DT, 16'h3fff);
		rd(OFS_TRG_CTL, 16'hf03f);
		rd(OFS_TRG_CMP, 16'hffff);
		rd(OFS_MODE, 16'h0037);
		rd(3'h6, 16'h0000);
		rd(3'h7, 16'h0000);
		$display("test masks done");
		// random pin setups; fault cycle mode, limit enabled
		wr(OFS_MODE, 16'h0005);
		for (int i = 0; i < 32; i++) begin
			r = lfsr(r);
			pc = r & 16'hfffe;
			if (pc[11:10] == 2'b11) pc[11:10] = 2'b00;
			r = lfsr(r);
			s = r;
			@(posedge i_clock);
			i_gen_high <= s[0];
			i_fault_active <= s[1] & s[2];
			i_limit_active <= s[3];
			wr(OFS_PIN_CTL, pc);
			cs(1);
			{h, l} = {s[0], ~s[0]};
			if (pc[11:10] != 2'b00) l = (pc[11:10] == 2'b01) ? s[0] : 1'b0;
			if (pc[1]) {h, l} = {l, h};
			if (pc[9]) h = pc[7];
			if (pc[8]) l = pc[6];
			if (s[3]) {h, l} = pc[3:2];
			if (s[1] & s[2]) {h, l} = pc[5:4];
			h = (h ^ pc[13]) & pc[15];
			l = (l ^ pc[12]) & pc[14];
			pins(h, l);
		end
		@(posedge i_clock);
		{i_gen_high, i_fault_active, i_limit_active} <= 3'h0;
		cs(1);
		$display("test pins done");
		wr(OFS_PIN_CTL, 16'hc000);
		pins(1'b0, 1'b1);
		wr(OFS_PIN_CTL, 16'hc3c1);
		pins(1'b0, 1'b1);
		cs(1);
		pins(1'b1, 1'b1);
		wr(OFS_PIN_CTL, 16'hc020);
		pins(1'b0, 1'b1);
		$display("test sync done");
		wr(OFS_MODE, 16'h0000);
		@(posedge i_clock);
		i_fault_active <= 1'b1;
		@(posedge i_clock);
		i_fault_active <= 1'b0;
		cs(1);
		pins(1'b1, 1'b0);
		wr(OFS_MODE, 16'h0003);
		@(posedge i_clock);
		i_fault_active <= 1'b1;
		pins(1'b0, 1'b1);
		@(posedge i_clock);
		i_fault_active <= 1'b0;
		$display("test fault done");
		@(posedge i_clock);
		i_config_write_lock <= 1'b1;
		wr(OFS_PIN_CTL, 16'h4000);
		rd(OFS_PIN_CTL, 16'hc020);
		@(posedge i_clock);
		i_unlock_pulse <= 1'b1;
		@(posedge i_clock);
		i_unlock_pulse <= 1'b0;
		wr(OFS_PIN_CTL, 16'h4000);
		rd(OFS_PIN_CTL, 16'h4000);
		wr(OFS_PIN_CTL, 16'hc000);
		rd(OFS_PIN_CTL, 16'h4000);
		@(posedge i_clock);
		i_config_write_lock <= 1'b0;
		$display("test lock done");
		wr(OFS_MAIN_DT, 16'h1234);
		wrd(OFS_ALT_DT, 16'h2abc, 16'h2abc);
		for (int d = 0; d < 4; d++) begin
			wr(OFS_MODE, 16'(d << 4));
			repeat (3) @(posedge i_clock);
			#1;
			chk({2'b00, o_rise_dead_time}, (d == 2) ? 16'h0 : 16'h1234);
			chk({2'b00, o_fall_dead_time}, (d == 2) ? 16'h0 : 16'h2abc);
			chk({14'h0, o_dead_time_negative, o_dead_time_comp},
				{14'h0, d == 1, d == 3});
		end
		$display("test dead time done");
		wr(OFS_TRG_CMP, 16'h0010);
		trg(4'h0, 6'h00, 1'b1, 0, 4, 4);
		trg(4'h2, 6'h03, 1'b1, 3, 7, 2);
		trg(4'hf, 6'h3f, 1'b1, 2, 16, 1);
		trg(4'h0, 6'h00, 1'b0, 0, 3, 0);
		chk(16'(n_irq2), 16'h0000);
		chk(16'(n_trg2), 16'h0007);
		$display("test trigger done");
		repeat (3) @(posedge i_clock);
		test_done();
	end
endmodule : pwmotc_top_tb
